// ==== common/tcd_pkg.sv ====
// shared constants of the thermostat command decoder
package tcd_pkg;
    localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
    localparam logic [7:0] CMD_START_A = 8'hEE;
    localparam logic [7:0] CMD_START_B = 8'h51;
    localparam logic [7:0] CMD_STOP = 8'h22;
    localparam logic [7:0] CMD_CONFIG = 8'hAC;
    localparam logic [7:0] CMD_HIGH = 8'hA1;
    localparam logic [7:0] CMD_LOW = 8'hA2;
    localparam logic [7:0] CMD_COUNTER = 8'hA8;
    localparam logic [7:0] CMD_SLOPE = 8'hA9;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam int CFG_SINGLE = 0;
    localparam int CFG_POL = 1;
    localparam int CFG_RES = 2;
    localparam int CFG_NVB = 4;
    localparam int CFG_LOW = 5;
    localparam int CFG_HIGH = 6;
    localparam int CFG_DONE = 7;
    localparam logic SINGLE_RST = 1'b0;
    localparam logic POL_RST = 1'b1;
    localparam logic [1:0] RES_RST = 2'h0;
    localparam logic DONE_RST = 1'b0;
    localparam logic [15:0] THRESH_HIGH_RST = 16'h0000;
    localparam logic [15:0] THRESH_LOW_RST = 16'h0000;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] TEMP_IN_RST = 16'h0000;
    localparam logic [15:0] RES9_KEEP_N = 16'h007F;
    localparam logic [3:0] ADDR_BASE = 4'h9;
    localparam logic [7:0] SLOPE_DEF = 8'h10;
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_MASK = 3'h1;
    localparam logic [2:0] REG_TEMP_IN = 3'h2;
    localparam logic [2:0] REG_CONFIG = 3'h3;
    localparam logic [2:0] REG_THRESH = 3'h4;
    localparam logic [2:0] REG_RESULT = 3'h5;
    localparam int ST_DONE = 0;
    localparam int ST_HIGH = 1;
    localparam int ST_LOW = 2;
    localparam int ST_CMD = 3;
    localparam int ST_W = 4;
    localparam int CLK_HZ = 10_000_000;
    localparam int CONV_TIME_US = 400;
    localparam int NV_WRITE_US = 10_000;
    localparam int CONV_CYCLES_DEF = (CONV_TIME_US * (CLK_HZ / 1_000_000));
    localparam int NV_BUSY_CYCLES_DEF = (NV_WRITE_US * (CLK_HZ / 1_000_000));
endpackage

// ==== hw/tcd_converter.sv ====
// conversion sequencer: one-shot or continuous, resolution-scaled time
`timescale 1ns/100ps
module tcd_converter #(
    parameter int CONV_CYCLES = tcd_pkg::CONV_CYCLES_DEF
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic single_i,
    input wire logic [1:0] res_i,
    input wire logic [15:0] temp_i,
    output logic busy_o,
    output logic done_o,
    output logic done_pulse_o,
    output logic [15:0] result_o
);
    import tcd_pkg::*;
    logic [23:0] cnt_reg;
    logic run_reg;
    wire [23:0] limit = 24'(CONV_CYCLES) << res_i;
    // >= so a resolution change mid-conversion cannot overrun the count
    wire conv_end = busy_o & (cnt_reg >= limit - 24'h000001);
    wire [15:0] keep_mask = ~(RES9_KEEP_N >> res_i);
    wire run_next = start_i ? ~single_i : (run_reg & ~stop_i);
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
            done_o <= DONE_RST;
            done_pulse_o <= 1'b0;
            result_o <= RESULT_RST;
            cnt_reg <= 24'h000000;
            run_reg <= 1'b0;
        end else begin
            done_pulse_o <= conv_end;
            run_reg <= run_next;
            if (conv_end) begin
                result_o <= temp_i & keep_mask;
                done_o <= 1'b1;
                cnt_reg <= 24'h000000;
                busy_o <= run_next;
            end else if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                done_o <= 1'b0;
                cnt_reg <= 24'h000000;
            end else if (busy_o) begin
                cnt_reg <= cnt_reg + 24'h000001;
            end
        end
    end
endmodule // tcd_converter

// ==== hw/tcd_link_slave.sv ====
// two-wire byte engine: address match, ack, byte receive and send
`timescale 1ns/100ps
module tcd_link_slave (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] addr_sel_i,
    input wire logic [7:0] tx_data_i,
    output logic sda_oe_n_o,
    output logic rx_valid_o,
    output logic rx_first_o,
    output logic [7:0] rx_data_o,
    output logic tx_load_o,
    output logic start_o
);
    import tcd_pkg::*;
    typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ACKA, L_WR, L_ACKW, L_RD,
        L_ACKR} tcd_link_t;
    tcd_link_t state_reg;
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [2:0] addr_m, addr_s;
    logic [7:0] sh_reg;
    logic [3:0] bit_reg;
    logic rw_reg, ack_reg, first_reg;
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
    wire addr_hit = (sh_reg[7:1] == {ADDR_BASE, addr_s});
    wire last_bit = (bit_reg == 4'h8);
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
            {addr_m, addr_s} <= 6'h00;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
            {addr_m, addr_s} <= {addr_sel_i, addr_m};
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= L_IDLE;
            {sh_reg, bit_reg, rw_reg, ack_reg, first_reg} <= 15'h0000;
            {rx_valid_o, rx_first_o, tx_load_o, start_o} <= 4'h0;
            rx_data_o <= 8'h00;
            sda_oe_n_o <= 1'b1;
        end else begin
            rx_valid_o <= 1'b0;
            tx_load_o <= 1'b0;
            start_o <= start_c;
            if (start_c) begin
                state_reg <= L_ADDR;
                bit_reg <= 4'h0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_c) begin
                state_reg <= L_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (scl_rise) begin
                if (state_reg == L_ADDR || state_reg == L_WR) begin
                    sh_reg <= {sh_reg[6:0], sda_s};
                    bit_reg <= bit_reg + 4'h1;
                end
                if (state_reg == L_ACKR)
                    ack_reg <= ~sda_s;
            end else if (scl_fall) begin
                case (state_reg)
                    L_ADDR: if (last_bit) begin
                        rw_reg <= sh_reg[0];
                        sda_oe_n_o <= ~addr_hit;
                        state_reg <= addr_hit ? L_ACKA : L_IDLE;
                    end
                    L_ACKA, L_ACKR: begin
                        if (state_reg == L_ACKA && !rw_reg) begin
                            sda_oe_n_o <= 1'b1;
                            state_reg <= L_WR;
                            bit_reg <= 4'h0;
                            first_reg <= 1'b1;
                        end else if (state_reg == L_ACKA || ack_reg) begin
                            sh_reg <= {tx_data_i[6:0], 1'b0};
                            sda_oe_n_o <= tx_data_i[7];
                            bit_reg <= 4'h1;
                            tx_load_o <= 1'b1;
                            state_reg <= L_RD;
                        end else begin
                            sda_oe_n_o <= 1'b1;
                            state_reg <= L_IDLE;
                        end
                    end
                    L_WR: if (last_bit) begin
                        rx_data_o <= sh_reg;
                        rx_first_o <= first_reg;
                        first_reg <= 1'b0;
                        rx_valid_o <= 1'b1;
                        sda_oe_n_o <= 1'b0;
                        state_reg <= L_ACKW;
                    end
                    L_ACKW: begin
                        sda_oe_n_o <= 1'b1;
                        bit_reg <= 4'h0;
                        state_reg <= L_WR;
                    end
                    L_RD: if (last_bit) begin
                        sda_oe_n_o <= 1'b1;
                        state_reg <= L_ACKR;
                    end else begin
                        sda_oe_n_o <= sh_reg[7];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    default: state_reg <= L_IDLE;
                endcase
            end
        end
    end
endmodule // tcd_link_slave

// ==== hw/tcd_top.sv ====
// thermostat command decoder: command decode, thresholds, alarms, bus
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module tcd_top #(
    parameter int VARIANT = 0,
    parameter int CONV_CYCLES = tcd_pkg::CONV_CYCLES_DEF,
    parameter int NV_BUSY_CYCLES = tcd_pkg::NV_BUSY_CYCLES_DEF,
    parameter logic [7:0] SLOPE = tcd_pkg::SLOPE_DEF
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [2:0] addr_sel_i,
    output logic thermostat_o,
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o
);
    import tcd_pkg::*;

    localparam bit VAR_A = (VARIANT == 0);

    // link side
    logic rx_valid, rx_first, tx_load, link_start;
    logic [7:0] rx_data;
    logic [7:0] tx_byte;

    tcd_link_slave u_link (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_sel_i(addr_sel_i),
        .tx_data_i(tx_byte),
        .sda_oe_n_o(sda_oe_n_o),
        .rx_valid_o(rx_valid),
        .rx_first_o(rx_first),
        .rx_data_o(rx_data),
        .tx_load_o(tx_load),
        .start_o(link_start)
    );

    // command and pointer state
    logic [7:0] cmd_reg;
    logic [1:0] wr_idx_reg;
    logic [1:0] rd_idx_reg;

    // configuration and data
    logic single_reg, pol_reg;
    logic [1:0] res_reg;
    logic high_flag_reg, low_flag_reg;
    logic [15:0] high_reg, low_reg;
    logic [15:0] temp_in_reg;
    logic [23:0] nv_cnt_reg;
    logic active_reg;

    // converter
    logic conv_busy, conv_done, conv_pulse;
    logic [15:0] result;

    // register bus and interrupts
    logic [ST_W-1:0] status_reg, mask_reg;

    // command decode
    wire cmd_byte = rx_valid & rx_first;
    wire data_byte = rx_valid & ~rx_first;
    wire [7:0] start_code = VAR_A ? CMD_START_A : CMD_START_B;
    wire start_conv = cmd_byte & (rx_data == start_code);
    wire stop_conv = cmd_byte & (rx_data == CMD_STOP);
    wire cfg_wr = data_byte & (cmd_reg == CMD_CONFIG)
        & (wr_idx_reg == 2'h0);
    wire high_wr = data_byte & (cmd_reg == CMD_HIGH);
    wire low_wr = data_byte & (cmd_reg == CMD_LOW);
    wire msb_slot = (wr_idx_reg == 2'h0);
    wire lsb_slot = (wr_idx_reg == 2'h1);
    wire nv_write = VAR_A & (cfg_wr | ((high_wr | low_wr)
        & (msb_slot | lsb_slot)));
    wire nonvolatile_busy_bit = VAR_A & (nv_cnt_reg != 24'h000000);

    // thermostat comparisons happen once per finished conversion
    wire over_high = $signed(result) > $signed(high_reg);
    wire under_low = $signed(result) <= $signed(low_reg);
    wire high_set = conv_pulse & over_high;
    wire low_set = conv_pulse & under_low;
    // on the first variant zero written clears, one written leaves the flag; set still wins
    wire high_clr = VAR_A & cfg_wr & ~rx_data[CFG_HIGH];
    wire low_clr = VAR_A & cfg_wr & ~rx_data[CFG_LOW];
    wire high_flag_next = high_set | (high_flag_reg & ~high_clr);
    wire low_flag_next = low_set | (low_flag_reg & ~low_clr);
    wire active_next = over_high & conv_pulse ? 1'b1 :
        (under_low & conv_pulse ? 1'b0 : active_reg);

    // configuration byte as seen on the link
    wire [1:0] res_eff = VAR_A ? 2'h0 : res_reg;
    wire [7:0] cfg_byte = {conv_done, high_flag_reg, low_flag_reg, nonvolatile_busy_bit,
        res_eff, pol_reg, single_reg};

    // read byte selection, advanced by each byte the engine loads
    wire rd_lsb = (rd_idx_reg != 2'h0);
    wire [7:0] counter_byte = SLOPE - {4'h0, result[7:4]};
    wire [7:0] temp_byte = rd_lsb ? result[7:0] : result[15:8];
    wire [7:0] high_byte = rd_lsb ? high_reg[7:0] : high_reg[15:8];
    wire [7:0] low_byte = rd_lsb ? low_reg[7:0] : low_reg[15:8];
    assign tx_byte =
        (cmd_reg == CMD_READ_TEMP) ? temp_byte :
        (cmd_reg == CMD_CONFIG) ? cfg_byte :
        (cmd_reg == CMD_HIGH) ? high_byte :
        (cmd_reg == CMD_LOW) ? low_byte :
        (VAR_A && cmd_reg == CMD_COUNTER) ? counter_byte :
        (VAR_A && cmd_reg == CMD_SLOPE) ? SLOPE :
        IDLE_BYTE;

    tcd_converter #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(start_conv),
        .stop_i(stop_conv),
        .single_i(single_reg),
        .res_i(res_eff),
        .temp_i(temp_in_reg),
        .busy_o(conv_busy),
        .done_o(conv_done),
        .done_pulse_o(conv_pulse),
        .result_o(result)
    );

    // command register and byte pointers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_reg <= CMD_RST;
            wr_idx_reg <= 2'h0;
            rd_idx_reg <= 2'h0;
        end else begin
            if (cmd_byte) begin
                cmd_reg <= rx_data;
                wr_idx_reg <= 2'h0;
            end else if (data_byte && wr_idx_reg != 2'h3) begin
                wr_idx_reg <= wr_idx_reg + 2'h1;
            end
            // a repeated start keeps the command, so reads follow it
            if (link_start)
                rd_idx_reg <= 2'h0;
            else if (tx_load && rd_idx_reg != 2'h3)
                rd_idx_reg <= rd_idx_reg + 2'h1;
        end
    end

    // configuration bits
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            single_reg <= SINGLE_RST;
            pol_reg <= POL_RST;
            res_reg <= RES_RST;
        end else if (cfg_wr) begin
            single_reg <= rx_data[CFG_SINGLE];
            pol_reg <= rx_data[CFG_POL];
            res_reg <= rx_data[CFG_RES +: 2];
        end
    end

    // alarm flags: only reset clears them on the second variant
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_flag_reg <= 1'b0;
            low_flag_reg <= 1'b0;
        end else begin
            high_flag_reg <= high_flag_next;
            low_flag_reg <= low_flag_next;
        end
    end

    // thresholds, most significant byte first
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_reg <= THRESH_HIGH_RST;
            low_reg <= THRESH_LOW_RST;
        end else begin
            if (high_wr && msb_slot)
                high_reg[15:8] <= rx_data;
            if (high_wr && lsb_slot)
                high_reg[7:0] <= rx_data;
            if (low_wr && msb_slot)
                low_reg[15:8] <= rx_data;
            if (low_wr && lsb_slot)
                low_reg[7:0] <= rx_data;
        end
    end

    // nonvolatile write time; writes during it are still accepted
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i)
            nv_cnt_reg <= 24'h000000;
        else if (nv_write)
            nv_cnt_reg <= 24'(NV_BUSY_CYCLES);
        else if (nv_cnt_reg != 24'h000000)
            nv_cnt_reg <= nv_cnt_reg - 24'h000001;
    end

    // thermostat output with programmable level
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_reg <= 1'b0;
            thermostat_o <= ~POL_RST;
            sda_o <= 1'b0;
        end else begin
            active_reg <= active_next;
            thermostat_o <= pol_reg ? active_next : ~active_next;
            sda_o <= 1'b0;
        end
    end

    // register bus: one wait cycle, then the access completes
    wire bus_req = avs_read_i | avs_write_i;
    wire bus_done = bus_req & ~avs_waitrequest_o;
    wire bus_wr = bus_done & avs_write_i;
    wire lane0 = avs_byteenable_i[0];
    wire lane1 = avs_byteenable_i[1];
    wire wr_status = bus_wr & lane0 & (avs_address_i == REG_STATUS);
    wire wr_mask = bus_wr & lane0 & (avs_address_i == REG_MASK);
    wire wr_temp = bus_wr & (avs_address_i == REG_TEMP_IN);
    wire [ST_W-1:0] status_clr = wr_status ? avs_writedata_i[ST_W-1:0]
        : {ST_W{1'b0}};
    wire [ST_W-1:0] events;
    assign events[ST_DONE] = conv_pulse;
    assign events[ST_HIGH] = high_set;
    assign events[ST_LOW] = low_set;
    assign events[ST_CMD] = cmd_byte;
    // an event in the clearing cycle survives the clear
    wire [ST_W-1:0] status_next = events | (status_reg & ~status_clr);
    wire [31:0] rd_mux =
        (avs_address_i == REG_STATUS) ? {28'h0000000, status_reg} :
        (avs_address_i == REG_MASK) ? {28'h0000000, mask_reg} :
        (avs_address_i == REG_TEMP_IN) ? {16'h0000, temp_in_reg} :
        (avs_address_i == REG_CONFIG) ? {15'h0000, conv_busy,
            cmd_reg, cfg_byte} :
        (avs_address_i == REG_THRESH) ? {high_reg, low_reg} :
        (avs_address_i == REG_RESULT) ? {15'h0000, active_reg, result} :
        32'h00000000;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            // writes leave the last read word standing
            if (bus_req && avs_waitrequest_o && avs_read_i)
                avs_readdata_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_reg <= {ST_W{1'b0}};
            mask_reg <= {ST_W{1'b0}};
            temp_in_reg <= TEMP_IN_RST;
            irq_o <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_o <= |(status_next & mask_reg);
            if (wr_mask)
                mask_reg <= avs_writedata_i[ST_W-1:0];
            if (wr_temp && lane0)
                temp_in_reg[7:0] <= avs_writedata_i[7:0];
            if (wr_temp && lane1)
                temp_in_reg[15:8] <= avs_writedata_i[15:8];
        end
    end
endmodule // tcd_top

// ==== testbench/tcd_sva.sv ====
// port checker for the thermostat command decoder
`timescale 1ns/100ps
module tcd_chk (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic thermostat_o,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    sequence req_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence req_done;
        req_taken ##1 !avs_waitrequest_o;
    endsequence
    chk_one_wait: assert property (req_taken |=> !avs_waitrequest_o)
        else $error("waitrequest not low after request");
    chk_wait_back: assert property (req_done |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_wait_idle: assert property (!(avs_read_i || avs_write_i)
        && $past(!(avs_read_i || avs_write_i)) |-> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    chk_rdata_hold: assert property ($changed(avs_readdata_o)
        |-> $past(avs_read_i && avs_waitrequest_o))
        else $error("read data moved without a read");
    chk_sda_pull: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    chk_oe_scl_low: assert property ($changed(sda_oe_n_o)
        |-> !scl_i && !$past(scl_i))
        else $error("data enable moved while link clock high");
    chk_reset_idle: assert property ($past(!resetn_i) |-> sda_oe_n_o
        && !thermostat_o && avs_waitrequest_o && !irq_o)
        else $error("outputs not idle after reset");
    chk_irq_cause: assert property ($fell(irq_o)
        |-> $past(avs_write_i, 2) || $past(avs_write_i, 3))
        else $error("interrupt fell without a write");
endmodule // tcd_chk
bind tcd_top tcd_chk tcd_chk_i (.clk_sys_i, .resetn_i, .scl_i, .sda_o,
    .sda_oe_n_o, .thermostat_o, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .irq_o);

// ==== testbench/tcd_master.sv ====
// two-wire bus master model facing the decoder's link pins
`timescale 1ns/100ps
module tcd_master (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic ack_n;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // a released line reads the pull-up level, never the last bit
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        #200 scl_o = 1'b1;
        r = sda_i;
        #400 scl_o = 1'b0;
        #200;
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    endtask
    task automatic start;
        sda_o = 1'b1;
        #200 scl_o = 1'b1;
        #200 sda_o = 1'b0;
        #200 scl_o = 1'b0;
        #200;
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic rd, input int n,
        input logic [15:0] wd, output logic [15:0] q);
        logic [7:0] b;
        q = 16'h0000;
        start;
        byte_io({tcd_pkg::ADDR_BASE, 3'h0, 1'b0}, b);
        bit_io(1'b1, ack_n);
        byte_io(cmd, b);
        bit_io(1'b1, ack_n);
        if (rd) begin
            start;
            byte_io({tcd_pkg::ADDR_BASE, 3'h0, 1'b1}, b);
            bit_io(1'b1, ack_n);
        end
        for (int i = 0; i < n; i++) begin
            byte_io(rd ? 8'hFF : wd[15 - 8 * i -: 8], b);
            if (rd) q[15 - 8 * i -: 8] = b;
            bit_io(rd ? (i == n - 1) : 1'b1, ack_n);
        end
        sda_o = 1'b0;
        #200 scl_o = 1'b1;
        #200 sda_o = 1'b1;
        #400;
    endtask
endmodule // tcd_master

// ==== testbench/tb_top.sv ====
// self-checking bench for the thermostat command decoder
`timescale 1ns/100ps
module tb_top;
    import tcd_pkg::*;
    logic clk_sys_i, resetn_i, scl, m_sda, sda_o, sda_oe_n_o;
    logic thermostat_o, irq_o, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [2:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, r;
    logic [3:0] avs_byteenable_i;
    logic [15:0] q;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    wire sda_w = m_sda & (sda_oe_n_o | sda_o);
    tcd_top #(.CONV_CYCLES(16), .NV_BUSY_CYCLES(50)) tcd_top_i (.clk_sys_i,
        .resetn_i, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_n_o,
        .addr_sel_i(3'h0), .thermostat_o, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .irq_o);
    tcd_master tcd_master_i (.sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            print_verdict;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // answer taken at a rising edge; only the cycle limit ends the wait
    task automatic bus(input logic w, input logic [2:0] a, input int d);
        @(posedge clk_sys_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic lnk(input logic [7:0] c, input logic rd, input int n,
        input logic [15:0] d);
        // keeps every link edge off the sampling edge of the clock
        @(negedge clk_sys_i);
        tcd_master_i.xfer(c, rd, n, d, q);
    endtask
    // bounded wait: a missing interrupt shows up as a miscompare
    task automatic wait_irq;
        int n = 0;
        do @(negedge clk_sys_i); while (irq_o !== 1'b1 && ++n < 300);
        repeat (3) @(negedge clk_sys_i);
    endtask
    task automatic t_regs;
        bus(0, REG_CONFIG, 0);
        chk("config", 32'h2, r);
        bus(0, 3'h7, 0);
        chk("unmapped", 0, r);
        lnk(CMD_HIGH, 0, 2, 16'h1800);
        lnk(CMD_LOW, 0, 2, 16'h1400);
        lnk(CMD_HIGH, 1, 2, 0);
        chk("high", 16'h1800, q);
        lnk(CMD_LOW, 1, 2, 0);
        chk("low", 16'h1400, q);
        bus(0, REG_THRESH, 0);
        chk("thresh", 32'h18001400, r);
        $display("test regs done");
    endtask
    task automatic t_conv;
        bus(1, REG_TEMP_IN, 32'h19C0);
        bus(1, REG_MASK, 32'h1);
        lnk(CMD_CONFIG, 0, 1, 16'h0300);
        bus(0, REG_CONFIG, 0);
        chk("nv busy", 1, r[CFG_NVB]);
        lnk(CMD_START_A, 0, 0, 0);
        wait_irq;
        chk("tout", 1, thermostat_o);
        bus(0, REG_RESULT, 0);
        chk("result", 32'h11980, r);
        lnk(CMD_READ_TEMP, 1, 2, 0);
        chk("temp", 16'h1980, q);
        bus(0, REG_CONFIG, 0);
        chk("busy", 0, r[16]);
        lnk(CMD_CONFIG, 1, 1, 0);
        chk("cfg", 16'hC300, q);
        lnk(CMD_COUNTER, 1, 1, 0);
        chk("counter", {SLOPE_DEF - 8'h08, 8'h00}, q);
        lnk(CMD_SLOPE, 1, 1, 0);
        chk("slope", {SLOPE_DEF, 8'h00}, q);
        bus(1, REG_STATUS, 32'hF);
        repeat (3) @(negedge clk_sys_i);
        chk("irq clear", 0, irq_o);
        lnk(CMD_CONFIG, 0, 1, 16'h2300);
        lnk(CMD_CONFIG, 1, 1, 0);
        chk("high flag", 0, q[14]);
        $display("test conv done");
    endtask
    task automatic t_stop;
        lnk(CMD_CONFIG, 0, 1, 16'h0000);
        lnk(CMD_START_A, 0, 0, 0);
        wait_irq;
        bus(1, REG_STATUS, 32'h1);
        wait_irq;
        chk("again", 1, irq_o);
        chk("tout low", 0, thermostat_o);
        lnk(CMD_STOP, 0, 0, 0);
        repeat (40) @(negedge clk_sys_i);
        bus(1, REG_STATUS, 32'h1);
        wait_irq;
        chk("stopped", 0, irq_o);
        lnk(CMD_START_B, 0, 0, 0);
        wait_irq;
        chk("other start", 0, irq_o);
        $display("test stop done");
    endtask
    initial begin
        resetn_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 3'h0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'hF;
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_regs;
        t_conv;
        t_stop;
        print_verdict;
    end
endmodule // tb_top
